// [design/rca_pkg.sv]
package rca_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int STRAP_SETTLE_NS = 10000;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PFW_HALF_PERIOD_NS = 500000;
  localparam int PFW_HALF_CYC = PFW_HALF_PERIOD_NS / CLK_PERIOD_NS;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SETPOINT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // status field positions
  localparam int ST_MODE = 0;
  localparam int ST_VALID = 1;
  localparam int ST_ADDR = 2;
  localparam int ST_OVERRIDE = 6;
  localparam int ST_MAIN_ON = 7;
  localparam int ST_INVALID = 8;
  localparam int ST_LATCHED = 9;
  // serial bus addresses
  localparam logic [2:0] ADDR_UPPER = 3'h4;
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  // setpoint programming in millivolts
  localparam logic [11:0] SETPOINT_PROGRAM_PIN_MIN_MV = 12'h064; // 100
  localparam logic [11:0] SETPOINT_PROGRAM_PIN_MAX_MV = 12'hBB8; // 3000
  localparam logic [15:0] SPT_MIN_MV = 16'h4650; // 18000
  localparam logic [15:0] SPT_DEFAULT_MV = 16'hC350; // 50000
  localparam logic [14:0] SPT_SCALE = 15'h372C; // 40000/2900 in 1/1024 steps
  // unit level decision thresholds, midpoints between nominal levels
  localparam logic [11:0] UNIT_THR [0:9] = '{12'h0B4, 12'h20D, 12'h357, 12'h4A1,
    12'h5EB, 12'h735, 12'h87F, 12'h9C9, 12'hB13, 12'hC4E};
  // shelf level windows, index 0 is rack 1
  localparam logic [11:0] RACK_MIN [0:7] = '{12'hC4E, 12'h3FC, 12'h708, 12'h226,
    12'h622, 12'h320, 12'h546, 12'hA96};
  localparam logic [11:0] RACK_MAX [0:7] = '{12'hD98, 12'h46A, 12'h7C6, 12'h258,
    12'h6CC, 12'h370, 12'h5D2, 12'hBB8};
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_ACK_ARM = 3'b010,
    S_ACK_DRIVE = 3'b011, S_WAIT = 3'b100
  } rca_i2c_e;
endpackage

// [design/rca_cfg_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface rca_cfg_if;
  logic [3:0] raw_addr;
  logic raw_valid;
  logic [3:0] addr;
  logic addr_valid;
  logic mode_i2c;
  logic gc_read;
  logic addr_hit;
  modport dec (output raw_addr, raw_valid);
  modport top (input raw_addr, raw_valid, gc_read, addr_hit, output addr, addr_valid, mode_i2c);
  modport bus (input addr, addr_valid, mode_i2c, output gc_read, addr_hit);
endinterface // rca_cfg_if
`default_nettype wire

// [design/rca_id_decode.sv]
`timescale 1ns/10ps
`default_nettype none
module rca_id_decode import rca_pkg::*; (
  // quantised levels in millivolts
  input wire logic [11:0] i_unit_level,
  input wire logic [11:0] i_shelf_level,
  // decoded address
  rca_cfg_if.dec cfg
);
  logic [9:0] unit_gt;
  logic [7:0] rack_hit;
  logic [3:0] unit_cnt;
  logic [3:0] u0;
  logic [3:0] r0;
  logic [5:0] a;
  logic ok;
  // per-threshold and per-window compares
  genvar k;
  for (k = 0; k < 10; k++) begin : g_unit
    assign unit_gt[k] = i_unit_level > UNIT_THR[k];
  end
  for (k = 0; k < 8; k++) begin : g_rack
    assign rack_hit[k] = i_shelf_level >= RACK_MIN[k] && i_shelf_level <= RACK_MAX[k];
  end
  // unit and rack codes, zero based, and the shelf maps
  always_comb begin
    unit_cnt = 4'h0;
    r0 = 4'hF;
    for (int j = 0; j < 10; j++) unit_cnt = unit_cnt + {3'h0, unit_gt[j]};
    for (int j = 7; j >= 0; j--) if (rack_hit[j]) r0 = 4'(j);
    u0 = 4'(4'h9 - unit_cnt); // 0 is unit 1
    ok = 1'b1;
    a = 6'h00;
    if (unit_cnt == 4'hA || r0 == 4'hF) begin
      ok = 1'b0;
    end else if (u0 <= 4'h3 && r0 <= 4'h3) begin
      a = 6'({r0, 2'h0} + {2'h0, u0});
    end else if (u0 <= 4'h4 && r0 >= 4'h5) begin
      a = 6'(({2'h0, r0} - 6'h05) * 6'h05 + {2'h0, u0});
    end else if (u0 == 4'h5 || u0 == 4'h6) begin
      a = 6'({r0, 1'b0} + {2'h0, u0} - 6'h05);
    end else if (u0 >= 4'h7 && r0 >= 4'h3) begin
      a = 6'(({2'h0, r0} - 6'h03) * 6'h03 + {2'h0, u0} - 6'h07);
    end else begin
      ok = 1'b0;
    end
  end
  assign cfg.raw_addr = a[3:0];
  assign cfg.raw_valid = ok;
endmodule // rca_id_decode
`default_nettype wire

// [design/rca_i2c_addr.sv]
`timescale 1ns/10ps
`default_nettype none
module rca_i2c_addr import rca_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // synchronised bus lines
  input wire logic scl,
  input wire logic sda,
  // configuration and events
  rca_cfg_if.bus cfg,
  // data line pull-down enable
  output logic sda_oe
);
  rca_i2c_e st_r;
  logic scl_d_r, sda_d_r, ack_r, hit_r, gcr_r;
  logic [6:0] sh_r;
  logic [2:0] cnt_r;
  // line events and the address byte being completed
  wire rise = scl && !scl_d_r;
  wire fall = !scl && scl_d_r;
  wire start = scl && scl_d_r && sda_d_r && !sda;
  wire stop = scl && scl_d_r && !sda_d_r && sda;
  wire [7:0] byte_in = {sh_r, sda};
  wire live = cfg.addr_valid && cfg.mode_i2c;
  wire own = live && byte_in[7:1] == {ADDR_UPPER, cfg.addr};
  wire gc = live && byte_in[7:1] == GENERAL_CALL;
  // address phase state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      sh_r <= 7'h00;
      cnt_r <= 3'h0;
      ack_r <= 1'b0;
      sda_oe <= 1'b0;
      hit_r <= 1'b0;
      gcr_r <= 1'b0;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
      hit_r <= 1'b0;
      gcr_r <= 1'b0;
      if (start) begin
        st_r <= S_ADDR;
        cnt_r <= 3'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        st_r <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_r)
          S_ADDR: if (rise) begin
            sh_r <= byte_in[6:0];
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
              ack_r <= own || (gc && !byte_in[0]);
              gcr_r <= gc && byte_in[0];
              hit_r <= own || (gc && !byte_in[0]);
              st_r <= S_ACK_ARM;
            end
          end
          S_ACK_ARM: if (fall) begin
            sda_oe <= ack_r;
            st_r <= S_ACK_DRIVE;
          end
          S_ACK_DRIVE: if (fall) begin
            sda_oe <= 1'b0;
            st_r <= S_WAIT;
          end
          S_IDLE, S_WAIT: st_r <= st_r;
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end
  assign cfg.addr_hit = hit_r;
  assign cfg.gc_read = gcr_r;
endmodule // rca_i2c_addr
`default_nettype wire

// [design/rca_top.sv]
// Overview of operation
// - open strap selects serial bus, resistor multi-drop
// - answer on 7-bit address 100 plus four bits
// - address byte bit 0 is direction, 1 reads
// - also accept the all-zero general call
// - general call read gives invalid command, no data
// - unit level gives ten codes, top invalid
// - shelf level gives eight rack codes by windows
// - 4x4 and 5x3 shelf address maps
// - 2x8 and 3x5 shelf address maps
// - serial mode needs interlock to rail for power
// - software setpoint overrides pin until bias cycle
// - pin sets output only between 0.1 and 3.0V
// - above 3V default setpoint, else 18 to 58V
// - multi-drop mode ignores program, share, on/off, fault
// - serial mode output on only with on/off low and interlock
// - in serial mode releasing either pin turns output off
// - presence output held low while inserted
// - warning high while output delivered, low on shutdown
// - warning pulses with 1ms period in overload
// - fault low on replacement failures
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module rca_top import rca_pkg::*; #(
  parameter int P_PFW_HALF_CYC = PFW_HALF_CYC
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // configuration straps and levels
  input wire logic I_MODE_STRAP,
  input wire logic [11:0] I_UNIT_POSITION_LEVEL,
  input wire logic [11:0] I_SHELF_POSITION_LEVEL,
  input wire logic I_SLOT_INTERLOCK_STRAP,
  // control pins
  input wire logic I_ON_OFF_N,
  input wire logic [11:0] I_SETPOINT_PROGRAM_PIN,
  // internal condition inputs
  input wire logic I_OVERLOAD,
  input wire logic I_PROTECT_TRIP,
  input wire logic I_FAN_FAIL,
  input wire logic I_OVER_TEMP,
  input wire logic I_OVER_VOLT,
  input wire logic I_INTERNAL_FAULT,
  // serial bus
  input wire logic I_SCL,
  input wire logic I_SDA_IN,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  // power stage and status outputs
  output logic O_MAIN_ON,
  output logic [15:0] O_SETPOINT_MV,
  output logic O_LOAD_SHARE_EN,
  output logic O_POWER_FAIL_WARN_N,
  output logic O_FAULT_N,
  output logic O_PRESENT_N,
  output logic O_MODE_I2C
);
  localparam int SYNC_W = 47;
  localparam int SET_W = $clog2(STRAP_SETTLE_CYC + 1);
  localparam int PFW_W = $clog2(P_PFW_HALF_CYC + 1);

  rca_cfg_if cfg ();

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SET_W-1:0] settle_r;
  logic latched_r;
  logic mode_r;
  logic [3:0] addr_r;
  logic valid_r;
  logic [31:0] ctrl_r;
  logic [15:0] sw_spt_r;
  logic override_r;
  logic invalid_r;
  logic [15:0] hw_spt_r;
  logic [PFW_W-1:0] pfw_cnt_r;
  logic pfw_tgl_r;
  logic sda_oe;

  // two-flop synchroniser for every pin input
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {I_MODE_STRAP, I_SLOT_INTERLOCK_STRAP, I_ON_OFF_N, I_OVERLOAD,
        I_PROTECT_TRIP, I_FAN_FAIL, I_OVER_TEMP, I_OVER_VOLT, I_INTERNAL_FAULT,
        I_SCL, I_SDA_IN, I_UNIT_POSITION_LEVEL, I_SHELF_POSITION_LEVEL,
        I_SETPOINT_PROGRAM_PIN};
      sync2_r <= sync1_r;
    end
  end

  // synchronised pin views
  wire mode_s = sync2_r[46];
  wire interlock_n_s = sync2_r[45];
  wire on_off_n_s = sync2_r[44];
  wire overload_s = sync2_r[43];
  wire protect_s = sync2_r[42];
  wire fan_s = sync2_r[41];
  wire ot_s = sync2_r[40];
  wire ov_s = sync2_r[39];
  wire intf_s = sync2_r[38];
  wire scl_s = sync2_r[37];
  wire sda_s = sync2_r[36];
  wire [11:0] unit_s = sync2_r[35:24];
  wire [11:0] shelf_s = sync2_r[23:12];
  wire [11:0] setpoint_program_pin_s = sync2_r[11:0];

  // level decode and address recognition
  rca_id_decode u_dec (
    .i_unit_level(unit_s),
    .i_shelf_level(shelf_s),
    .cfg(cfg.dec)
  );

  rca_i2c_addr u_i2c (
    .clk(I_CLOCK),
    .rst_n(I_ARST_N),
    .scl(scl_s),
    .sda(sda_s),
    .cfg(cfg.bus),
    .sda_oe(sda_oe)
  );

  assign cfg.mode_i2c = mode_r;
  assign cfg.addr = addr_r;
  assign cfg.addr_valid = valid_r;

  // strap latch after the settle delay following reset release
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      settle_r <= '0;
      latched_r <= 1'b0;
      mode_r <= 1'b0;
      addr_r <= 4'h0;
      valid_r <= 1'b0;
    end else if (!latched_r) begin
      settle_r <= SET_W'(settle_r + 1'b1);
      if (settle_r == SET_W'(STRAP_SETTLE_CYC - 1)) begin
        latched_r <= 1'b1;
        mode_r <= mode_s;
        addr_r <= cfg.raw_addr;
        valid_r <= cfg.raw_valid;
      end
    end
  end

  // apb decode: one wait state, write takes effect at the ready edge
  wire apb_access = I_PSEL && I_PENABLE && !O_PREADY;
  wire apb_done = I_PSEL && I_PENABLE && O_PREADY;
  wire sel_ctrl = I_PADDR == REG_CTRL;
  wire sel_spt = I_PADDR == REG_SETPOINT;
  wire sel_stat = I_PADDR == REG_STATUS;
  wire mapped = sel_ctrl || sel_spt || sel_stat;
  wire wr_ctrl = apb_done && I_PWRITE && sel_ctrl;
  wire wr_spt = apb_done && I_PWRITE && sel_spt;
  wire wr_stat = apb_done && I_PWRITE && sel_stat;

  // status word
  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_MODE] = mode_r;
    status_w[ST_VALID] = valid_r;
    status_w[ST_ADDR +: 4] = addr_r;
    status_w[ST_OVERRIDE] = override_r;
    status_w[ST_MAIN_ON] = O_MAIN_ON;
    status_w[ST_INVALID] = invalid_r;
    status_w[ST_LATCHED] = latched_r;
  end

  // read data mux
  wire [31:0] rdata = sel_ctrl ? ctrl_r :
    sel_spt ? {16'h0000, sw_spt_r} :
    sel_stat ? status_w : 32'h0000_0000;

  // apb handshake outputs
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= apb_access;
      O_PRDATA <= apb_access && !I_PWRITE ? rdata : 32'h0000_0000;
      O_PSLVERR <= apb_access && !mapped;
    end
  end

  // software registers; the override holds until reset (bias cycle)
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_r <= CTRL_RST;
      sw_spt_r <= SPT_DEFAULT_MV;
      override_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= {31'h0, I_PWDATA[0]};
      if (wr_spt) begin
        sw_spt_r <= I_PWDATA[15:0];
        override_r <= 1'b1;
      end
    end
  end

  // invalid command flag: a new event wins over a write-one clear
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      invalid_r <= 1'b0;
    end else if (cfg.gc_read) begin
      invalid_r <= 1'b1;
    end else if (wr_stat && I_PWDATA[ST_INVALID]) begin
      invalid_r <= 1'b0;
    end
  end

  // hardware setpoint from the program pin
  wire setpoint_program_pin_in_range = setpoint_program_pin_s >= SETPOINT_PROGRAM_PIN_MIN_MV && setpoint_program_pin_s <= SETPOINT_PROGRAM_PIN_MAX_MV;
  wire setpoint_program_pin_high = setpoint_program_pin_s > SETPOINT_PROGRAM_PIN_MAX_MV;
  wire [11:0] setpoint_program_pin_off = 12'(setpoint_program_pin_s - SETPOINT_PROGRAM_PIN_MIN_MV);
  wire [26:0] setpoint_program_pin_prod = 27'(setpoint_program_pin_off * SPT_SCALE);
  wire [15:0] hw_scaled = 16'(SPT_MIN_MV + 16'(setpoint_program_pin_prod[26:10]));

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hw_spt_r <= SPT_DEFAULT_MV;
    end else if (setpoint_program_pin_high) begin
      hw_spt_r <= SPT_DEFAULT_MV;
    end else if (setpoint_program_pin_in_range) begin
      hw_spt_r <= hw_scaled;
    end
  end

  // setpoint selection; multi-drop mode never looks at the pin
  wire [15:0] spt_sel = override_r ? sw_spt_r :
    !mode_r ? SPT_DEFAULT_MV : hw_spt_r;

  // output enable and failure terms
  wire failure = fan_s || ot_s || ov_s || intf_s;
  wire pin_on = !on_off_n_s && !interlock_n_s;
  wire ms_on = ctrl_r[0] && !interlock_n_s;
  wire on_req = latched_r && (mode_r ? pin_on : ms_on);
  wire on_nxt = on_req && !protect_s && !failure;

  // overload warning toggle, half period count
  wire pfw_wrap = pfw_cnt_r == PFW_W'(P_PFW_HALF_CYC - 1);
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pfw_cnt_r <= '0;
      pfw_tgl_r <= 1'b0;
    end else if (!overload_s) begin
      pfw_cnt_r <= '0;
      pfw_tgl_r <= 1'b0;
    end else if (pfw_wrap) begin
      pfw_cnt_r <= '0;
      pfw_tgl_r <= !pfw_tgl_r;
    end else begin
      pfw_cnt_r <= PFW_W'(pfw_cnt_r + 1'b1);
    end
  end

  // registered pin outputs
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_MAIN_ON <= 1'b0;
      O_SETPOINT_MV <= SPT_DEFAULT_MV;
      O_LOAD_SHARE_EN <= 1'b0;
      O_POWER_FAIL_WARN_N <= 1'b0;
      O_FAULT_N <= 1'b1;
      O_PRESENT_N <= 1'b0;
      O_MODE_I2C <= 1'b0;
      O_SDA_OUT <= 1'b0;
      O_SDA_OE <= 1'b0;
    end else begin
      O_MAIN_ON <= on_nxt;
      O_SETPOINT_MV <= spt_sel;
      O_LOAD_SHARE_EN <= latched_r && mode_r;
      O_POWER_FAIL_WARN_N <= overload_s && O_MAIN_ON ? pfw_tgl_r : on_nxt;
      O_FAULT_N <= !(latched_r && mode_r && failure);
      O_PRESENT_N <= 1'b0;
      O_MODE_I2C <= mode_r;
      O_SDA_OUT <= 1'b0;
      O_SDA_OE <= sda_oe;
    end
  end
endmodule // rca_top
`default_nettype wire

// [bench/rca_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// host bus master: drives the bus clock and pulls data low; both idle high
module rca_host_model #(
  parameter int HALF_NS = 80
) (
  // bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one clock pulse with data set while low, data sampled mid high
  task automatic clk_bit(input logic low, output logic seen);
    scl = 1'b0;
    #(HALF_NS / 2);
    sda_low = low;
    #(HALF_NS / 2);
    scl = 1'b1;
    #(HALF_NS / 2);
    seen = sda;
    #(HALF_NS / 2);
  endtask
  // start, address byte msb first, ack clock, stop
  task automatic addr_phase(input logic [7:0] b, output logic ack);
    logic s;
    #3;
    sda_low = 1'b1;
    #(HALF_NS);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], s);
    end
    clk_bit(1'b0, s);
    ack = ~s;
    scl = 1'b0;
    #(HALF_NS / 2);
    sda_low = 1'b1;
    #(HALF_NS / 2);
    scl = 1'b1;
    #(HALF_NS / 2);
    sda_low = 1'b0;
    #(HALF_NS);
  endtask
endmodule // rca_host_model
`default_nettype wire

// [bench/rca_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module rca_top_asserts #(
  parameter int P_PFW_HALF_CYC = 8
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  // pins and conditions
  input wire logic I_SLOT_INTERLOCK_STRAP,
  input wire logic I_ON_OFF_N,
  input wire logic I_OVERLOAD,
  input wire logic I_PROTECT_TRIP,
  input wire logic I_FAN_FAIL,
  input wire logic I_OVER_TEMP,
  input wire logic I_OVER_VOLT,
  input wire logic I_INTERNAL_FAULT,
  // watched outputs
  input wire logic O_SDA_OE,
  input wire logic O_MAIN_ON,
  input wire logic O_POWER_FAIL_WARN_N,
  input wire logic O_FAULT_N,
  input wire logic O_PRESENT_N,
  input wire logic O_MODE_I2C
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_ARST_N);
  // helper terms and a counter of cycles the warning held still in overload
  wire pins_ok = !I_ON_OFF_N && !I_SLOT_INTERLOCK_STRAP;
  wire failed = I_FAN_FAIL || I_OVER_TEMP || I_OVER_VOLT || I_INTERNAL_FAULT;
  logic [15:0] hold_r;
  logic [15:0] hold_nxt;
  logic last_r;
  assign hold_nxt = (O_MAIN_ON && I_OVERLOAD && O_POWER_FAIL_WARN_N == last_r) ? hold_r + 16'h1 : 16'h0;
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hold_r <= 16'h0;
      last_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      last_r <= O_POWER_FAIL_WARN_N;
    end
  end
  AST_PRESENT_LOW: assert property (!O_PRESENT_N)
    else $error("presence output not low");
  AST_LOCK_OFF: assert property ($rose(I_SLOT_INTERLOCK_STRAP) |-> ##[1:5] !O_MAIN_ON)
    else $error("output stayed on without interlock");
  AST_ONOFF_OFF: assert property ($rose(I_ON_OFF_N) && O_MODE_I2C |-> ##[1:5] !O_MAIN_ON)
    else $error("output stayed on after on/off release");
  AST_ON_NEEDS_PINS: assert property (O_MAIN_ON && O_MODE_I2C |-> $past(pins_ok, 3) || $past(pins_ok, 4))
    else $error("output on without both pins");
  AST_TRIP_OFF: assert property (I_PROTECT_TRIP |-> ##[1:6] (!O_MAIN_ON && !O_POWER_FAIL_WARN_N))
    else $error("protection did not shut down");
  AST_WARN_OFF: assert property (!O_MAIN_ON && !$past(O_MAIN_ON) |-> !O_POWER_FAIL_WARN_N)
    else $error("warning high while output off");
  AST_WARN_PULSE: assert property (hold_r <= 16'(P_PFW_HALF_CYC + 4))
    else $error("warning not pulsing in overload");
  AST_FAULT_LOW: assert property (failed && O_MODE_I2C |-> ##[1:5] !O_FAULT_N)
    else $error("fault output not low");
  AST_MD_SILENT: assert property (!O_MODE_I2C |-> !O_SDA_OE)
    else $error("acknowledge outside serial mode");
  COV_ACK: cover property ($rose(O_SDA_OE));
  COV_ON: cover property ($rose(O_MAIN_ON));
  COV_FAULT: cover property ($fell(O_FAULT_N));
endmodule // rca_top_asserts
bind rca_top rca_top_asserts #(.P_PFW_HALF_CYC(P_PFW_HALF_CYC)) u_asserts (
  .I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N), .I_SLOT_INTERLOCK_STRAP(I_SLOT_INTERLOCK_STRAP),
  .I_ON_OFF_N(I_ON_OFF_N), .I_OVERLOAD(I_OVERLOAD), .I_PROTECT_TRIP(I_PROTECT_TRIP),
  .I_FAN_FAIL(I_FAN_FAIL), .I_OVER_TEMP(I_OVER_TEMP), .I_OVER_VOLT(I_OVER_VOLT),
  .I_INTERNAL_FAULT(I_INTERNAL_FAULT), .O_SDA_OE(O_SDA_OE), .O_MAIN_ON(O_MAIN_ON),
  .O_POWER_FAIL_WARN_N(O_POWER_FAIL_WARN_N), .O_FAULT_N(O_FAULT_N),
  .O_PRESENT_N(O_PRESENT_N), .O_MODE_I2C(O_MODE_I2C));
`default_nettype wire

// [bench/rectifier_control_addr_logic_test.sv]
`timescale 1ns/10ps
`default_nettype none
module rectifier_control_addr_logic_test;
  import rca_pkg::*;
  // bench drive and observed values
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic [11:0] unit_lv = 12'h000, shelf_lv = 12'h000, prog_lv = 12'h064;
  logic mode_strap = 1, lock = 1, on_off_n = 1, ovl = 0, trip = 0, e, ack, last;
  logic [3:0] fails = 4'h0;
  logic [15:0] spt;
  logic pready, pslverr, sda_out, sda_oe, main_on, share, pfw_n, fault_n, present_n, mode;
  wire scl, host_low;
  wire sda = !(host_low || (sda_oe && !sda_out));
  int bad_count = 0, samples_checked = 0, cycles = 0, n;
  logic [4:0] ea;
  logic [6:0] own;
  int tu [12] = '{1, 4, 5, 5, 6, 7, 10, 8, 5, 11, 9, 3};
  int tr [12] = '{1, 4, 6, 8, 1, 8, 8, 4, 5, 1, 3, 2};
  int rl [8] = '{3310, 1070, 1890, 580, 1660, 840, 1420, 2860};
  logic [3:0] pv [7] = '{4'h1, 4'h8, 4'h1, 4'h4, 4'h1, 4'h2, 4'h1};
  rca_top #(.P_PFW_HALF_CYC(8)) uut (
    .I_CLOCK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_MODE_STRAP(mode_strap), .I_UNIT_POSITION_LEVEL(unit_lv),
    .I_SHELF_POSITION_LEVEL(shelf_lv), .I_SLOT_INTERLOCK_STRAP(lock), .I_ON_OFF_N(on_off_n),
    .I_SETPOINT_PROGRAM_PIN(prog_lv), .I_OVERLOAD(ovl), .I_PROTECT_TRIP(trip),
    .I_FAN_FAIL(fails[0]), .I_OVER_TEMP(fails[1]), .I_OVER_VOLT(fails[2]),
    .I_INTERNAL_FAULT(fails[3]), .I_SCL(scl), .I_SDA_IN(sda), .O_SDA_OUT(sda_out),
    .O_SDA_OE(sda_oe), .O_MAIN_ON(main_on), .O_SETPOINT_MV(spt), .O_LOAD_SHARE_EN(share),
    .O_POWER_FAIL_WARN_N(pfw_n), .O_FAULT_N(fault_n), .O_PRESENT_N(present_n),
    .O_MODE_I2C(mode));
  rca_host_model host (.scl(scl), .sda_low(host_low), .sda(sda));
  // clock and hang limit
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 60000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // expected {valid, address} of a unit and rack code pair
  function automatic logic [4:0] exp_addr(int u, int r);
    if (u < 1 || u > 10) return 5'h00;
    if (u <= 4 && r <= 4) return {1'b1, 4'((r - 1) * 4 + u - 1)};
    if (u <= 5 && r >= 6) return {1'b1, 4'((r - 6) * 5 + u - 1)};
    if (u == 6 || u == 7) return {1'b1, 4'((r - 1) * 2 + u - 6)};
    if (u >= 8 && r >= 4) return {1'b1, 4'((r - 4) * 3 + u - 8)};
    return 5'h00;
  endfunction
  // nominal unit level in millivolts, code 11 is the invalid top level
  function automatic int ulv(int u);
    if (u > 10) return 3300;
    if (u == 10) return 0;
    return 3000 - 330 * (u - 1);
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  // reset pulse, then wait for the straps to be latched
  task automatic boot();
    @(posedge clk);
    arst_n <= 0;
    wt(2);
    arst_n <= 1;
    wt(STRAP_SETTLE_CYC + 10);
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    // address map over strap tables; last entry is multi-drop mode
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      mode_strap <= (k != 11);
      unit_lv <= 12'(ulv(tu[k]));
      shelf_lv <= 12'(rl[tr[k] - 1]);
      ea = exp_addr(tu[k], tr[k]);
      boot();
      apb(0, REG_STATUS, 0);
      chk("mode", k != 11, q[ST_MODE]);
      if (k != 11) chk("valid", ea[4], q[ST_VALID]);
      if (k != 11 && ea[4]) chk("addr", ea[3:0], q[ST_ADDR+:4]);
      ea[4] = ea[4] && k != 11;
      own = {3'b100, ea[3:0]};
      host.addr_phase({own, 1'b0}, ack);
      chk("ack_wr", ea[4], ack);
      host.addr_phase({own, 1'b1}, ack);
      chk("ack_rd", ea[4], ack);
      host.addr_phase({own ^ 7'h01, 1'b0}, ack);
      chk("ack_other", 0, ack);
      host.addr_phase(8'h00, ack);
      chk("ack_gc", ea[4], ack);
    end
    // multi-drop: program and on/off pins ignored, failures leave fault high, control register and interlock drive the output
    wt(1);
    prog_lv <= 12'd1550;
    on_off_n <= 0;
    lock <= 0;
    fails <= 4'h1;
    wt(6);
    chk("md_main", 0, main_on);
    chk("md_spt", SPT_DEFAULT_MV, spt);
    chk("md_fault", 1, fault_n);
    chk("md_share", 0, share);
    fails <= 4'h0;
    apb(1, REG_CTRL, 1);
    wt(6);
    chk("md_ctrl", 1, main_on);
    // serial mode, pin programmed setpoint
    mode_strap <= 1;
    on_off_n <= 1;
    lock <= 1;
    prog_lv <= 12'h064;
    unit_lv <= 12'd3000;
    shelf_lv <= 12'd3310;
    boot();
    chk("present", 0, present_n);
    chk("share", 1, share);
    chk("mode_pin", 1, mode);
    chk("sda_out", 0, sda_out);
    chk("spt_min", SPT_MIN_MV, spt);
    prog_lv <= 12'd3100;
    wt(6);
    chk("spt_dflt", SPT_DEFAULT_MV, spt);
    prog_lv <= 12'd1550;
    wt(6);
    chk("spt_mid", 1, spt > 16'd37900 && spt < 16'd38100);
    prog_lv <= 12'd50;
    wt(6);
    chk("spt_low", 1, spt > 16'd37900 && spt < 16'd38100);
    // on/off, interlock and protection sequence
    foreach (pv[j]) begin
      {on_off_n, lock, trip} <= pv[j][3:1];
      wt(6);
      chk("main_on", pv[j][0], main_on);
      chk("pfw", pv[j][0], pfw_n);
    end
    // overload makes the warning pulse
    ovl <= 1;
    wt(6);
    last = pfw_n;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += (pfw_n !== last);
      last = pfw_n;
    end
    chk("pfw_pulse", 1, n >= 4 && n <= 6);
    chk("ovl_main", 1, main_on);
    ovl <= 0;
    for (int f = 0; f < 4; f++) begin
      fails <= 4'(1 << f);
      wt(6);
      chk("fault", 0, fault_n);
      fails <= 4'h0;
      wt(1);
    end
    // general call read is refused and flagged
    host.addr_phase(8'h01, ack);
    chk("ack_gcrd", 0, ack);
    apb(0, REG_STATUS, 0);
    chk("invalid", 1, q[ST_INVALID]);
    apb(1, REG_STATUS, 32'(1) << ST_INVALID);
    apb(0, REG_STATUS, 0);
    chk("inv_clr", 0, q[ST_INVALID]);
    // software setpoint takes over until the next reset
    apb(1, REG_SETPOINT, 32'h0000_9C40);
    prog_lv <= 12'd3100;
    wt(6);
    chk("spt_sw", 16'h9C40, spt);
    apb(0, REG_STATUS, 0);
    chk("override", 1, q[ST_OVERRIDE]);
    apb(0, 8'h0C, 0);
    chk("slverr", 1, e);
    chk("rd_unmap", 0, q);
    prog_lv <= 12'h064;
    boot();
    chk("spt_pin", SPT_MIN_MV, spt);
    report_and_stop();
  end
endmodule // rectifier_control_addr_logic_test
`default_nettype wire
